// ### rtl/rpa_pkg.sv
// Register map, field layout and reset values of the prescaler, wakeup and alarm block
package rpa_pkg;

   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam logic [4:0] OFF_CONTROL = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h04;
   localparam logic [4:0] OFF_PRESCALER = 5'h08;
   localparam logic [4:0] OFF_WAKEUP = 5'h0C;
   localparam logic [4:0] OFF_ALARM_A = 5'h10;
   localparam logic [4:0] OFF_IRQ_STATUS = 5'h14;
   localparam logic [4:0] OFF_IRQ_MASK = 5'h18;
   localparam logic [4:0] OFF_WAKEUP_COUNT = 5'h1C;

   // ************************************************************
   // Control and status bit positions
   // ************************************************************
   localparam int CTL_INIT_REQUEST = 0;
   localparam int CTL_WAKEUP_ENABLE = 1;
   localparam int CTL_ALARM_ENABLE = 2;
   localparam int STS_ALARM_WRITABLE = 0;
   localparam int STS_WAKEUP_WRITABLE = 2;
   localparam int STS_INIT_ENTERED = 6;
   localparam int STS_ALARM_MATCH = 8;
   localparam int IRQ_ALARM = 0;
   localparam int IRQ_WAKEUP = 1;
   localparam int IRQ_BITS = 2;

   // ************************************************************
   // Prescaler fields
   // ************************************************************
   localparam int FIRST_LSB = 16;
   localparam int FIRST_MSB = 22;
   localparam int SECOND_LSB = 0;
   localparam int SECOND_MSB = 14;
   localparam logic [6:0] FIRST_RESET = 7'h7F;
   localparam logic [14:0] SECOND_RESET = 15'h00FF;

   // ************************************************************
   // Wakeup fields
   // ************************************************************
   localparam int RELOAD_LSB = 0;
   localparam int RELOAD_MSB = 15;
   localparam logic [15:0] RELOAD_RESET = 16'hFFFF;

   // ************************************************************
   // Alarm A fields
   // ************************************************************
   localparam int ALM_DAY_IGNORE = 31;
   localparam int ALM_DAY_KIND = 30;
   localparam int ALM_DAY_TENS_LSB = 28;
   localparam int ALM_DAY_TENS_MSB = 29;
   localparam int ALM_DAY_UNITS_LSB = 24;
   localparam int ALM_DAY_UNITS_MSB = 27;
   localparam int ALM_HOUR_IGNORE = 23;
   localparam int ALM_HALF_DAY = 22;
   localparam int ALM_HOUR_TENS_LSB = 20;
   localparam int ALM_HOUR_TENS_MSB = 21;

   // Flag clear reaches the flag this many bus cycles after the write
   localparam int CLEAR_DELAY = 2;

endpackage

// ### rtl/rpa_prescaler.sv
// Two cascaded counters that derive the calendar tick from source clock edges
`timescale 1ns/100ps
module rpa_prescaler (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hold,
   input wire logic src_edge,
   input wire logic [6:0] first_prescale_factor,
   input wire logic [14:0] second_prescale_factor,
   output logic tick
);
   import rpa_pkg::*;

   typedef struct packed {
      logic [6:0] count_first;
      logic [14:0] count_second;
      logic tick;
   } rpa_presc_type;

   rpa_presc_type state;
   rpa_presc_type next_state;

   // ************************************************************
   // Counter update
   // ************************************************************
   // First stage wraps at its factor and steps the second
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (hold) begin
         next_state.count_first = '0;
         next_state.count_second = '0;
      end else if (src_edge) begin
         if (state.count_first >= first_prescale_factor) begin // R15
            next_state.count_first = '0;
            if (state.count_second >= second_prescale_factor) begin // R1
               next_state.count_second = '0;
               next_state.tick = 1'b1;
            end else begin
               next_state.count_second = state.count_second + 15'h0001;
            end
         end else begin
            next_state.count_first = state.count_first + 7'h01;
         end
      end
   end

   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign tick = state.tick;

endmodule

// ### rtl/rpa_rtc_cfg.sv
// Prescaler, wakeup reload and alarm A configuration with Avalon-MM registers
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// What this block does
// R1 - Tick equals source over the product of each factor plus one
// R2 - Sixteen bit wakeup reload, resets all ones
// R3 - Day mask bit drops day from match
// R4 - Day kind: date, or weekday units only
// R5 - Day held as tens and units decimal
// R6 - Hour mask bit drops hours from match
// R7 - Half-day bit compared only in 12-hour
// R8 - Two-bit hour tens compared unless masked
// R9 - Reserved bits fixed, writes ignored
// R10 - Prescaler writable only in entered init mode
// R11 - Wakeup writable flag, resets to one
// R12 - Alarm writable flag, resets to one
// R13 - Match sets alarm flag; clear two cycles late
// R14 - Wakeup counter decrements, flags, reloads at zero
// R15 - Two cascaded prescaler counters
module rpa_rtc_cfg (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic rtc_source_clock,
   input wire logic [1:0] cal_date_tens,
   input wire logic [3:0] cal_date_units,
   input wire logic [3:0] cal_weekday,
   input wire logic [1:0] cal_hour_tens,
   input wire logic cal_pm,
   input wire logic cal_format_12h,
   output logic calendar_tick,
   output logic calendar_halt,
   output logic wakeup_tick,
   output logic irq
);
   import rpa_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] readdata;
      logic [2:0] control;
      logic init_mode_entered;
      logic [6:0] first_prescale_factor;
      logic [14:0] second_prescale_factor;
      logic [15:0] wakeup_reload;
      logic [15:0] wakeup_count;
      logic wakeup_tick;
      logic alarm_day_ignore;
      logic alarm_day_kind_select;
      logic [1:0] alarm_day_tens;
      logic [3:0] alarm_day_units;
      logic alarm_hour_ignore;
      logic alarm_half_day;
      logic [1:0] alarm_hour_tens;
      logic match_prev;
      logic [IRQ_BITS-1:0] irq_status;
      logic [IRQ_BITS-1:0] irq_mask;
      logic [IRQ_BITS-1:0] clear_stage1;
      logic [IRQ_BITS-1:0] clear_stage2;
      logic src_sync1;
      logic src_sync2;
      logic src_prev;
   } rpa_cfg_type;

   // All block state except the prescaler counters in one register
   rpa_cfg_type state;
   rpa_cfg_type next_state;

   logic presc_tick;
   logic src_edge;
   logic alarm_match;
   logic wakeup_writable;
   logic alarm_writable;
   logic prescaler_writable;
   logic take_write;
   logic take_read;
   logic [31:0] wmask;

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Expand byte enables into a bit mask
   function automatic logic [31:0] byte_mask(input logic [3:0] be);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // Merge write data into an old word under a bit mask
   function automatic logic [31:0] merge(input logic [31:0] old_word,
                                         input logic [31:0] data,
                                         input logic [31:0] mask);
      return (old_word & ~mask) | (data & mask);
   endfunction

   // Alarm comparison of unmasked fields
   function automatic logic day_hour_match(input rpa_cfg_type s,
                                           input logic [1:0] d_tens,
                                           input logic [3:0] d_units,
                                           input logic [3:0] wday,
                                           input logic [1:0] h_tens,
                                           input logic pm,
                                           input logic fmt12);
      logic day_ok;
      logic hour_ok;
      day_ok = 1'b1;
      hour_ok = 1'b1;
      if (!s.alarm_day_ignore) begin // R3
         if (s.alarm_day_kind_select) begin
            day_ok = (s.alarm_day_units == wday); // R4
         end else begin
            day_ok = (s.alarm_day_tens == d_tens) && (s.alarm_day_units == d_units); // R5
         end
      end
      if (!s.alarm_hour_ignore) begin // R6
         hour_ok = (s.alarm_hour_tens == h_tens); // R8
         if (fmt12) begin
            hour_ok = hour_ok && (s.alarm_half_day == pm); // R7
         end
      end
      return day_ok && hour_ok;
   endfunction

   // ************************************************************
   // Register images
   // ************************************************************
   // Prescaler word, reserved bits read zero
   function automatic logic [31:0] prescaler_word(input rpa_cfg_type s);
      logic [31:0] w;
      w = '0;
      w[FIRST_MSB:FIRST_LSB] = s.first_prescale_factor;
      w[SECOND_MSB:SECOND_LSB] = s.second_prescale_factor;
      return w;
   endfunction

   // Alarm word, reserved bits read zero
   function automatic logic [31:0] alarm_word(input rpa_cfg_type s);
      logic [31:0] w;
      w = '0;
      w[ALM_DAY_IGNORE] = s.alarm_day_ignore;
      w[ALM_DAY_KIND] = s.alarm_day_kind_select;
      w[ALM_DAY_TENS_MSB:ALM_DAY_TENS_LSB] = s.alarm_day_tens;
      w[ALM_DAY_UNITS_MSB:ALM_DAY_UNITS_LSB] = s.alarm_day_units;
      w[ALM_HOUR_IGNORE] = s.alarm_hour_ignore;
      w[ALM_HALF_DAY] = s.alarm_half_day;
      w[ALM_HOUR_TENS_MSB:ALM_HOUR_TENS_LSB] = s.alarm_hour_tens;
      return w;
   endfunction

   // ************************************************************
   // Prescaler instance
   // ************************************************************
   // Rising edge of the synchronised source pin
   // Only the second flop and the edge memory feed this compare, never the first
   assign src_edge = state.src_sync2 & ~state.src_prev;

   // Counters held at zero while init mode is entered
   rpa_prescaler u_prescaler (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .hold(state.init_mode_entered),
      .src_edge(src_edge),
      .first_prescale_factor(state.first_prescale_factor),
      .second_prescale_factor(state.second_prescale_factor),
      .tick(presc_tick)
   );

   // ************************************************************
   // Access qualifiers
   // ************************************************************
   // Write permission follows the enables and init mode
   assign wakeup_writable = ~state.control[CTL_WAKEUP_ENABLE]; // R11
   assign alarm_writable = ~state.control[CTL_ALARM_ENABLE]; // R12
   assign prescaler_writable = state.control[CTL_INIT_REQUEST] & state.init_mode_entered; // R10

   // Live match of the unmasked day and hour fields
   assign alarm_match = day_hour_match(state, cal_date_tens, cal_date_units, cal_weekday,
                                       cal_hour_tens, cal_pm, cal_format_12h);

   // Write lands at the acknowledge edge, read loads in the wait cycle
   assign take_write = avs_write & state.ack;
   assign take_read = avs_read & ~state.ack;
   assign wmask = byte_mask(avs_byteenable);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [31:0] word;
      logic [IRQ_BITS-1:0] set_ev;
      word = '0;
      set_ev = '0;
      next_state = state;

      // Source clock synchroniser and edge memory
      next_state.src_sync1 = rtc_source_clock;
      next_state.src_sync2 = state.src_sync1;
      next_state.src_prev = state.src_sync2;

      // One wait cycle per request
      // A request still held after the acknowledge opens a new access
      next_state.ack = (avs_read | avs_write) & ~state.ack;
      // Init entry seen one cycle after the request
      next_state.init_mode_entered = state.control[CTL_INIT_REQUEST];

      // Read data captured in the wait cycle
      if (take_read) begin
         unique case (avs_address)
            OFF_CONTROL: next_state.readdata = {29'h0000_0000, state.control};
            OFF_STATUS: begin
               word[STS_ALARM_WRITABLE] = alarm_writable;
               word[STS_WAKEUP_WRITABLE] = wakeup_writable;
               word[STS_INIT_ENTERED] = state.init_mode_entered;
               word[STS_ALARM_MATCH] = alarm_match;
               next_state.readdata = word;
            end
            OFF_PRESCALER: next_state.readdata = prescaler_word(state);
            OFF_WAKEUP: next_state.readdata = {16'h0000, state.wakeup_reload};
            OFF_ALARM_A: next_state.readdata = alarm_word(state);
            OFF_IRQ_STATUS: next_state.readdata = {30'h0000_0000, state.irq_status};
            OFF_IRQ_MASK: next_state.readdata = {30'h0000_0000, state.irq_mask};
            OFF_WAKEUP_COUNT: next_state.readdata = {16'h0000, state.wakeup_count};
            default: next_state.readdata = 32'h0000_0000;
         endcase
      end

      // Clear request pipeline
      next_state.clear_stage1 = '0;
      next_state.clear_stage2 = state.clear_stage1;

      // Register writes at the accepting edge
      if (take_write) begin
         unique case (avs_address)
            OFF_CONTROL: begin
               word = merge({29'h0000_0000, state.control}, avs_writedata, wmask);
               next_state.control = word[2:0];
            end
            OFF_PRESCALER: begin
               if (prescaler_writable) begin // R10
                  word = merge(prescaler_word(state), avs_writedata, wmask);
                  next_state.first_prescale_factor = word[FIRST_MSB:FIRST_LSB]; // R9
                  next_state.second_prescale_factor = word[SECOND_MSB:SECOND_LSB];
               end
            end
            OFF_WAKEUP: begin
               if (wakeup_writable) begin // R11
                  word = merge({16'h0000, state.wakeup_reload}, avs_writedata, wmask);
                  next_state.wakeup_reload = word[RELOAD_MSB:RELOAD_LSB]; // R2
               end
            end
            OFF_ALARM_A: begin
               if (alarm_writable) begin // R12
                  word = merge(alarm_word(state), avs_writedata, wmask);
                  next_state.alarm_day_ignore = word[ALM_DAY_IGNORE];
                  next_state.alarm_day_kind_select = word[ALM_DAY_KIND];
                  next_state.alarm_day_tens = word[ALM_DAY_TENS_MSB:ALM_DAY_TENS_LSB];
                  next_state.alarm_day_units = word[ALM_DAY_UNITS_MSB:ALM_DAY_UNITS_LSB];
                  next_state.alarm_hour_ignore = word[ALM_HOUR_IGNORE];
                  next_state.alarm_half_day = word[ALM_HALF_DAY];
                  next_state.alarm_hour_tens = word[ALM_HOUR_TENS_MSB:ALM_HOUR_TENS_LSB]; // R9
               end
            end
            OFF_IRQ_STATUS: begin
               if (avs_byteenable[0]) begin
                  next_state.clear_stage1 = avs_writedata[IRQ_BITS-1:0]; // R13
               end
            end
            OFF_IRQ_MASK: begin
               if (avs_byteenable[0]) begin
                  next_state.irq_mask = avs_writedata[IRQ_BITS-1:0];
               end
            end
            default: begin
               next_state.readdata = state.readdata;
            end
         endcase
      end

      // Wakeup counter: load while off, count calendar ticks while on
      // Pulse and flag one cycle after the tick that finds the count at zero
      next_state.wakeup_tick = 1'b0;
      if (!state.control[CTL_WAKEUP_ENABLE]) begin
         next_state.wakeup_count = state.wakeup_reload;
      end else if (presc_tick) begin
         if (state.wakeup_count == 16'h0000) begin
            next_state.wakeup_count = state.wakeup_reload; // R14
            next_state.wakeup_tick = 1'b1;
            set_ev[IRQ_WAKEUP] = 1'b1;
         end else begin
            next_state.wakeup_count = state.wakeup_count - 16'h0001; // R14
         end
      end

      // Alarm event on a new match while armed
      // Rising match only, so a standing match does not set the flag again
      next_state.match_prev = alarm_match;
      if (state.control[CTL_ALARM_ENABLE] && alarm_match && !state.match_prev) begin
         set_ev[IRQ_ALARM] = 1'b1; // R13
      end

      // Delayed clear, a set in the same cycle wins
      // Keeps an event that arrives during the clear from being lost
      next_state.irq_status = (state.irq_status & ~state.clear_stage2) | set_ev; // R13
   end

   // ************************************************************
   // State register
   // ************************************************************
   // Reset values from the package; ce low holds every field
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= '0;
         state.first_prescale_factor <= FIRST_RESET; // R1
         state.second_prescale_factor <= SECOND_RESET;
         state.wakeup_reload <= RELOAD_RESET; // R2
         state.wakeup_count <= RELOAD_RESET;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Wait state and irq decoded from flops, data straight from flops
   assign avs_waitrequest = ~state.ack;
   assign avs_readdata = state.readdata;
   assign calendar_tick = presc_tick;
   assign calendar_halt = state.init_mode_entered;
   assign wakeup_tick = state.wakeup_tick;
   assign irq = |(state.irq_status & state.irq_mask);

endmodule

// ### tb/rpa_rtc_cfg_props.sv
// Port-level assertions for the prescaler, wakeup and alarm block
`timescale 1ns/100ps
module rpa_rtc_cfg_props
   import rpa_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic calendar_tick,
   input wire logic calendar_halt,
   input wire logic wakeup_tick,
   input wire logic irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic req;
   logic wr_done;
   // Pending request and committed write
   assign req = avs_read | avs_write;
   assign wr_done = avs_write & ~avs_waitrequest & ce;
   // ************************************************************
   // Bus timing
   // ************************************************************
   a_wait_once: assert property (req && avs_waitrequest && ce |=> !avs_waitrequest)
      else $error("request waited more than one cycle");
   a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("acknowledge longer than one cycle");
   a_idle_wait: assert property (!req |-> avs_waitrequest)
      else $error("acknowledge without request");
   // ************************************************************
   // Prescaler, wakeup and interrupt
   // ************************************************************
   a_tick_pulse: assert property (calendar_tick |=> !calendar_tick)
      else $error("calendar tick wider than one cycle");
   a_halt_no_tick: assert property (calendar_halt && $past(calendar_halt) |-> !calendar_tick)
      else $error("calendar tick while halted");
   a_halt_follows: assert property (wr_done && avs_address == OFF_CONTROL && avs_byteenable[0]
      && avs_writedata[CTL_INIT_REQUEST] |-> ##[1:3] calendar_halt)
      else $error("init request not followed by halt");
   a_wake_after_tick: assert property (wakeup_tick |-> $past(calendar_tick))
      else $error("wakeup tick without calendar tick");
   a_wake_pulse: assert property (wakeup_tick |=> !wakeup_tick)
      else $error("wakeup tick wider than one cycle");
   a_mask_quiets: assert property (wr_done && avs_address == OFF_IRQ_MASK
      && avs_byteenable[0] && avs_writedata[1:0] == 2'b00 |=> !irq)
      else $error("irq high with all sources masked");
   // Main scenarios reached
   c_tick: cover property (calendar_tick);
   c_wake: cover property (wakeup_tick);
   c_irq: cover property (irq);
   c_halt: cover property (calendar_halt);
endmodule

// ### tb/tb_rpa_rtc_cfg.sv
// Self-checking bench for the prescaler, wakeup and alarm block
`timescale 1ns/100ps
module tb_rpa_rtc_cfg;
   import rpa_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic rtc_source_clock = 1'b0;
   logic [1:0] cal_date_tens = 2'h0;
   logic [3:0] cal_date_units = 4'h0;
   logic [3:0] cal_weekday = 4'h0;
   logic [1:0] cal_hour_tens = 2'h0;
   logic cal_pm = 1'b0;
   logic cal_format_12h = 1'b0;
   logic calendar_tick;
   logic calendar_halt;
   logic wakeup_tick;
   logic irq;
   int n_mismatch = 0;
   int tests_run = 0;
   int cycles = 0;
   int t;
   logic [2:0] src_div = 3'h0;
   logic [31:0] rd;
   logic [31:0] alm_tab [9];
   logic [13:0] cal_tab [9];
   logic exp_tab [9];
   localparam logic [31:0] ALL = 32'hFFFF_FFFF;

   rpa_rtc_cfg dut (.mclk, .rst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .rtc_source_clock, .cal_date_tens,
      .cal_date_units, .cal_weekday, .cal_hour_tens, .cal_pm, .cal_format_12h,
      .calendar_tick, .calendar_halt, .wakeup_tick, .irq);

   // ************************************************************
   // Clock, source clock and hang guard
   // ************************************************************
   always #4 mclk = ~mclk;
   // Source clock at one eighth of the bus clock
   always @(posedge mclk) begin
      src_div <= src_div + 3'h1;
      rtc_source_clock <= src_div[2];
   end
   // Hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   // ************************************************************
   // Bus tasks and compares
   // ************************************************************
   task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      access(1'b1, a, d);
      @(posedge mclk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      access(1'b0, a, 32'h0000_0000);
      check(rd & m, e);
   endtask
   task automatic bit_chk(input logic f, input logic e);
      check({31'h0000_0000, f}, {31'h0000_0000, e});
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      // Alarm word, calendar {dt,du,wd,ht,pm,fmt}, expected live match
      alm_tab = '{32'h1520_0000, 32'h1520_0000, 32'h9520_0000, 32'h6320_0000, 32'h6320_0000,
         32'h1510_0000, 32'h1590_0000, 32'h1560_0000, 32'h1560_0000};
      cal_tab = '{14'h1508, 14'h1608, 14'h1608, 14'h0938, 14'h0948,
         14'h1508, 14'h1508, 14'h1509, 14'h1508};
      exp_tab = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      // Reset values
      rd_chk(OFF_PRESCALER, ALL, 32'h007F_00FF);
      rd_chk(OFF_WAKEUP, ALL, 32'h0000_FFFF);
      rd_chk(OFF_ALARM_A, ALL, 32'h0000_0000);
      rd_chk(OFF_STATUS, 32'h0000_0045, 32'h0000_0005);
      // Reserved bits and an unmapped address
      wr(OFF_WAKEUP, 32'hFFFF_1234);
      rd_chk(OFF_WAKEUP, ALL, 32'h0000_1234);
      wr(OFF_ALARM_A, ALL);
      rd_chk(OFF_ALARM_A, ALL, 32'hFFF0_0000);
      wr(5'h13, 32'h0000_0000);
      rd_chk(OFF_ALARM_A, ALL, 32'hFFF0_0000);
      rd_chk(5'h13, ALL, 32'h0000_0000);
      // Prescaler locked until init mode is entered
      wr(OFF_PRESCALER, 32'h0001_0002);
      rd_chk(OFF_PRESCALER, ALL, 32'h007F_00FF);
      wr(OFF_CONTROL, 32'h0000_0001);
      t = 0;
      do begin
         access(1'b0, OFF_STATUS, 32'h0000_0000);
         t++;
      end while (rd[STS_INIT_ENTERED] !== 1'b1 && t < 10);
      wr(OFF_PRESCALER, 32'h8001_8002);
      rd_chk(OFF_PRESCALER, ALL, 32'h0001_0002);
      bit_chk(calendar_halt, 1'b1);
      wr(OFF_CONTROL, 32'h0000_0000);
      // Tick period of 2 x 3 source edges, 8 bus cycles each
      do @(posedge mclk); while (calendar_tick !== 1'b1);
      // Clock enable low freezes the prescaler
      ce <= 1'b0;
      t = 0;
      repeat (60) begin
         @(posedge mclk);
         if (calendar_tick === 1'b1) t++;
      end
      ce <= 1'b1;
      check(t, 0);
      do @(posedge mclk); while (calendar_tick !== 1'b1);
      t = 0;
      do begin
         @(posedge mclk);
         t++;
      end while (calendar_tick !== 1'b1);
      check(t, 48);
      // Wakeup every reload plus one ticks, write lock, interrupt
      wr(OFF_WAKEUP, 32'h0000_0002);
      wr(OFF_IRQ_MASK, 32'h0000_0002);
      wr(OFF_CONTROL, 32'h0000_0002);
      rd_chk(OFF_STATUS, 32'h0000_0004, 32'h0000_0000);
      wr(OFF_WAKEUP, 32'h0000_0005);
      rd_chk(OFF_WAKEUP, ALL, 32'h0000_0002);
      do @(posedge mclk); while (wakeup_tick !== 1'b1);
      t = 0;
      do begin
         @(posedge mclk);
         if (calendar_tick === 1'b1) t++;
      end while (wakeup_tick !== 1'b1);
      check(t, 3);
      rd_chk(OFF_IRQ_STATUS, 32'h0000_0002, 32'h0000_0002);
      bit_chk(irq, 1'b1);
      wr(OFF_IRQ_MASK, 32'h0000_0000);
      bit_chk(irq, 1'b0);
      wr(OFF_IRQ_MASK, 32'h0000_0002);
      bit_chk(irq, 1'b1);
      wr(OFF_IRQ_STATUS, 32'h0000_0002);
      bit_chk(irq, 1'b1);
      repeat (2) @(posedge mclk);
      rd_chk(OFF_IRQ_STATUS, 32'h0000_0002, 32'h0000_0000);
      bit_chk(irq, 1'b0);
      wr(OFF_CONTROL, 32'h0000_0000);
      // Live alarm match across masks and day kinds
      for (int i = 0; i < 9; i++) begin
         wr(OFF_ALARM_A, alm_tab[i]);
         {cal_date_tens, cal_date_units, cal_weekday, cal_hour_tens, cal_pm,
            cal_format_12h} <= cal_tab[i];
         rd_chk(OFF_STATUS, 32'h0000_0100, {23'h00_0000, exp_tab[i], 8'h00});
      end
      // Alarm event on a rising match, with write lock
      wr(OFF_ALARM_A, 32'h1520_0000);
      {cal_date_tens, cal_date_units, cal_weekday, cal_hour_tens, cal_pm,
         cal_format_12h} <= 14'h1608;
      wr(OFF_IRQ_MASK, 32'h0000_0001);
      wr(OFF_CONTROL, 32'h0000_0004);
      rd_chk(OFF_STATUS, 32'h0000_0001, 32'h0000_0000);
      wr(OFF_ALARM_A, 32'h0000_0000);
      rd_chk(OFF_ALARM_A, ALL, 32'h1520_0000);
      rd_chk(OFF_IRQ_STATUS, 32'h0000_0001, 32'h0000_0000);
      cal_date_units <= 4'h5;
      repeat (3) @(posedge mclk);
      bit_chk(irq, 1'b1);
      rd_chk(OFF_IRQ_STATUS, 32'h0000_0001, 32'h0000_0001);
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      bit_chk(irq, 1'b1);
      repeat (2) @(posedge mclk);
      rd_chk(OFF_IRQ_STATUS, 32'h0000_0001, 32'h0000_0000);
      bit_chk(irq, 1'b0);
      give_verdict();
   end
endmodule

bind rpa_rtc_cfg rpa_rtc_cfg_props u_props (.mclk, .rst, .ce, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest, .calendar_tick,
   .calendar_halt, .wakeup_tick, .irq);
